// ---- fbse_top.sv ----
/*
  Flash erase block select, power-down control, register gate, reset-time mode
  selection and boot entry sequence over the boot serial link.
  Assumes one clock, a synchronous active-high reset, pins stable around reset
  release, and an external flash eraser answering erase_all_req_o.
*/
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module fbse_top #(
  parameter int CNT_W = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [fbse_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [fbse_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output var logic [fbse_pkg::DATA_W-1:0] reg_rdata_o,
  // Mode pins
  input wire logic test_i,
  input wire logic nmi_n_i,
  input wire logic port8_bit5_i,
  input wire logic portb_bit0_i,
  input wire logic portb_bit1_i,
  input wire logic portb_bit2_i,
  output var fbse_pkg::fbse_mode_t mode_o,
  output var logic mode_valid_o,
  // Chip status
  input wire logic subactive_i,
  input wire logic flash_error_i,
  input wire logic watchdog_ovf_i,
  output var logic flash_power_down_o,
  // Erase region
  output var logic erase_region_valid_o,
  output var logic [15:0] erase_first_o,
  output var logic [15:0] erase_last_o,
  // Boot serial unit
  input wire logic rxd_i,
  output var logic txd_o,
  output var logic serial_rx_enable_o,
  output var logic serial_tx_enable_o,
  output var logic [CNT_W-1:0] bit_rate_reg_o,
  // Boot RAM load and erase
  output var logic ram_we_o,
  output var logic [15:0] ram_addr_o,
  output var logic [7:0] ram_wdata_o,
  output var logic erase_all_req_o,
  input wire logic erase_all_done_i,
  output var logic boot_branch_o,
  output var logic boot_active_o
);
  import fbse_pkg::*;

  logic test_s, nmi_n_s, p85_s, pb0_s, pb1_s, pb2_s, rxd_s;
  logic rst_d_reg, rxd_prev_reg;
  logic swe_reg;
  logic [5:0] ctl_low_reg;
  logic [EBR_W-1:0] ebr_reg;
  logic power_down_disable_reg, gate_reg;
  logic ctl_ok, wr_ctl, wr_ebr, wr_pwr, wr_gate;
  fbse_boot_t state_reg;
  logic [CNT_W-1:0] cnt_reg, bit_cycles_reg;
  logic [15:0] len_reg, ram_ptr_reg;
  logic erased_reg, rx_en_reg, tx_en_reg;
  logic rx_busy_reg, rx_valid_reg;
  logic [3:0] rx_bit_reg;
  logic [CNT_W-1:0] rx_cnt_reg;
  logic [7:0] rx_shift_reg, rx_data_reg;
  logic tx_start_reg, tx_busy_reg;
  logic [7:0] tx_byte_reg;
  logic [3:0] tx_bit_reg;
  logic [CNT_W-1:0] tx_cnt_reg;
  logic [FRAME_BITS-1:0] tx_frame_reg;

  // Pin synchronisers
  fbse_sync3 #(.W(7)) u_sync (
    .clk_i(clk_i),
    .d_i({test_i, nmi_n_i, port8_bit5_i, portb_bit0_i, portb_bit1_i, portb_bit2_i, rxd_i}),
    .q_o({test_s, nmi_n_s, p85_s, pb0_s, pb1_s, pb2_s, rxd_s})
  );

  // Mode capture at first edge after release
  always_ff @(posedge clk_i) begin
    rst_d_reg <= srst_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_o <= FBSE_MODE_USER;
      mode_valid_o <= 1'b0;
    end else if (rst_d_reg) begin
      mode_valid_o <= 1'b1;
      if (test_s && !pb0_s && !pb1_s && !pb2_s) begin
        mode_o <= FBSE_MODE_PROG;
      end else if (!test_s && !nmi_n_s && p85_s) begin
        mode_o <= FBSE_MODE_BOOT;
      end else begin
        mode_o <= FBSE_MODE_USER;
      end
    end
  end

  // Register decode with gate
  assign ctl_ok = gate_reg;
  assign wr_ctl = reg_wr_i && ctl_ok && reg_addr_i == OFS_FLASH_CONTROL_ONE;
  assign wr_ebr = reg_wr_i && ctl_ok && reg_addr_i == OFS_ERASE_BLOCK_SELECT;
  assign wr_pwr = reg_wr_i && ctl_ok && reg_addr_i == OFS_FLASH_POWER_CONTROL;
  assign wr_gate = reg_wr_i && reg_addr_i == OFS_FLASH_REGISTER_GATE;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gate_reg <= REG_RESET[CTRL_REG_ACCESS_EN_BIT];
    end else if (wr_gate) begin
      gate_reg <= reg_wdata_i[CTRL_REG_ACCESS_EN_BIT];
    end
  end

  // First control register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      swe_reg <= REG_RESET[SW_WRITE_ENABLE_BIT];
      ctl_low_reg <= REG_RESET[5:0];
    end else if (wr_ctl) begin
      swe_reg <= reg_wdata_i[SW_WRITE_ENABLE_BIT];
      ctl_low_reg <= (swe_reg && reg_wdata_i[SW_WRITE_ENABLE_BIT]) ? reg_wdata_i[5:0]
                                                                   : 6'h00;
    end else if (!swe_reg) begin
      ctl_low_reg <= 6'h00;
    end
  end

  // Erase block select
  always_ff @(posedge clk_i) begin
    if (srst_i || !swe_reg) begin
      ebr_reg <= REG_RESET[EBR_W-1:0];
    end else if (wr_ebr) begin
      ebr_reg <= $onehot0(reg_wdata_i[EBR_W-1:0]) ? reg_wdata_i[EBR_W-1:0]
                                                   : 5'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      erase_region_valid_o <= 1'b0;
      erase_first_o <= 16'h0000;
      erase_last_o <= 16'h0000;
    end else begin
      erase_region_valid_o <= |ebr_reg;
      erase_first_o <= 16'h0000;
      erase_last_o <= 16'h0000;
      for (int i = 0; i < EBR_W; i++) begin
        if (ebr_reg[i]) begin
          erase_first_o <= REGION_FIRST[i];
          erase_last_o <= REGION_LAST[i];
        end
      end
    end
  end

  // Power control
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      power_down_disable_reg <= REG_RESET[POWER_DOWN_DISABLE_BIT];
    end else if (wr_pwr) begin
      power_down_disable_reg <= reg_wdata_i[POWER_DOWN_DISABLE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flash_power_down_o <= 1'b0;
    end else begin
      flash_power_down_o <= subactive_i && !power_down_disable_reg;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i || !reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= 8'h00;
      case (reg_addr_i)
        OFS_FLASH_REGISTER_GATE: reg_rdata_o[CTRL_REG_ACCESS_EN_BIT] <= gate_reg;
        OFS_FLASH_CONTROL_ONE: begin
          if (ctl_ok) begin
            reg_rdata_o[SW_WRITE_ENABLE_BIT] <= swe_reg;
            reg_rdata_o[5:0] <= ctl_low_reg;
          end
        end
        OFS_FLASH_STATUS_TWO: reg_rdata_o[FLASH_ERROR_BIT] <= ctl_ok && flash_error_i;
        OFS_ERASE_BLOCK_SELECT: begin
          if (ctl_ok) begin
            reg_rdata_o[EBR_W-1:0] <= ebr_reg;
          end
        end
        OFS_FLASH_POWER_CONTROL: reg_rdata_o[POWER_DOWN_DISABLE_BIT] <= ctl_ok && power_down_disable_reg;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Serial receiver, 8N1
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rxd_prev_reg <= 1'b1;
    end else begin
      rxd_prev_reg <= rxd_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || !rx_en_reg) begin
      rx_busy_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
      rx_bit_reg <= 4'h0;
      rx_cnt_reg <= '0;
      rx_shift_reg <= 8'h00;
      rx_data_reg <= 8'h00;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (rxd_prev_reg && !rxd_s) begin
          rx_busy_reg <= 1'b1;
          rx_bit_reg <= 4'h0;
          rx_cnt_reg <= bit_cycles_reg >> 1;
        end
      end else if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end else begin
        rx_cnt_reg <= bit_cycles_reg - 1'b1;
        rx_bit_reg <= rx_bit_reg + 1'b1;
        if (rx_bit_reg == 4'h0) begin
          rx_busy_reg <= !rxd_s;
        end else if (rx_bit_reg <= 4'(FRAME_DATA_BITS)) begin
          rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
        end else begin
          rx_busy_reg <= 1'b0;
          rx_valid_reg <= rxd_s;
          rx_data_reg <= rx_shift_reg;
        end
      end
    end
  end

  // Serial transmitter, 8N1, idles high
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_busy_reg <= 1'b0;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= '0;
      tx_frame_reg <= '1;
      txd_o <= 1'b1;
    end else if (tx_start_reg) begin
      tx_busy_reg <= 1'b1;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= '0;
      tx_frame_reg <= {1'b1, tx_byte_reg, 1'b0};
    end else if (tx_busy_reg) begin
      if (tx_cnt_reg != '0) begin
        tx_cnt_reg <= tx_cnt_reg - 1'b1;
      end else if (tx_bit_reg == 4'(FRAME_BITS)) begin
        tx_busy_reg <= 1'b0;
      end else begin
        txd_o <= tx_frame_reg[0];
        tx_frame_reg <= {1'b1, tx_frame_reg[FRAME_BITS-1:1]};
        tx_bit_reg <= tx_bit_reg + 1'b1;
        tx_cnt_reg <= bit_cycles_reg - 1'b1;
      end
    end
  end

  // Boot sequence
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= FBSE_B_IDLE;
      cnt_reg <= '0;
      bit_cycles_reg <= '0;
      len_reg <= 16'h0000;
      ram_ptr_reg <= RAM_LOAD_FIRST;
      erased_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      tx_start_reg <= 1'b0;
      tx_byte_reg <= ADJUST_DONE_BYTE;
      ram_we_o <= 1'b0;
      ram_addr_o <= 16'h0000;
      ram_wdata_o <= 8'h00;
      erase_all_req_o <= 1'b0;
      boot_branch_o <= 1'b0;
    end else begin
      tx_start_reg <= 1'b0;
      ram_we_o <= 1'b0;
      boot_branch_o <= 1'b0;
      if (watchdog_ovf_i && state_reg != FBSE_B_DONE) begin
        state_reg <= FBSE_B_DONE;
        rx_en_reg <= 1'b0;
        tx_en_reg <= 1'b0;
        erase_all_req_o <= 1'b0;
      end else begin
        case (state_reg)
          FBSE_B_IDLE: begin
            cnt_reg <= '0;
            if (mode_valid_o) begin
              state_reg <= (mode_o == FBSE_MODE_BOOT) ? FBSE_B_WAIT : FBSE_B_DONE;
            end
          end
          FBSE_B_WAIT: begin
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(READY_STATES - 2)) begin
              state_reg <= FBSE_B_FALL;
            end
          end
          FBSE_B_FALL: begin
            if (rxd_prev_reg && !rxd_s) begin
              state_reg <= FBSE_B_LOW;
              cnt_reg <= CNT_W'(1);
            end
          end
          FBSE_B_LOW: begin
            if (!rxd_s) begin
              if (cnt_reg != '1) begin
                cnt_reg <= cnt_reg + 1'b1;
              end
            end else begin
              state_reg <= FBSE_B_DIV;
              bit_cycles_reg <= '0;
            end
          end
          FBSE_B_DIV: begin
            if (cnt_reg >= CNT_W'(ZERO_BYTE_LOW_BITS)) begin
              cnt_reg <= cnt_reg - CNT_W'(ZERO_BYTE_LOW_BITS);
              bit_cycles_reg <= bit_cycles_reg + 1'b1;
            end else if (bit_cycles_reg == '0) begin
              state_reg <= FBSE_B_FALL;
            end else begin
              state_reg <= FBSE_B_ADJ;
              rx_en_reg <= 1'b1;
              tx_en_reg <= 1'b1;
              tx_byte_reg <= ADJUST_DONE_BYTE;
              tx_start_reg <= 1'b1;
            end
          end
          FBSE_B_ADJ: begin
            if (!tx_start_reg && !tx_busy_reg) begin
              state_reg <= FBSE_B_ACK;
            end
          end
          FBSE_B_ACK: begin
            if (rx_valid_reg && rx_data_reg == HOST_ACK_BYTE) begin
              state_reg <= FBSE_B_LEN_HI;
            end
          end
          FBSE_B_LEN_HI: begin
            if (rx_valid_reg) begin
              len_reg[15:8] <= rx_data_reg;
              state_reg <= FBSE_B_LEN_LO;
            end
          end
          FBSE_B_LEN_LO: begin
            if (rx_valid_reg) begin
              len_reg[7:0] <= rx_data_reg;
              ram_ptr_reg <= RAM_LOAD_FIRST;
              state_reg <= ({len_reg[15:8], rx_data_reg} == 16'h0000) ? FBSE_B_ERASE
                                                                        : FBSE_B_LOAD;
            end
          end
          FBSE_B_LOAD: begin
            if (rx_valid_reg) begin
              ram_we_o <= 1'b1;
              ram_addr_o <= ram_ptr_reg;
              ram_wdata_o <= rx_data_reg;
              ram_ptr_reg <= ram_ptr_reg + 1'b1;
              len_reg <= len_reg - 1'b1;
              if (len_reg == 16'h0001 || ram_ptr_reg == RAM_LOAD_LAST) begin
                state_reg <= FBSE_B_ERASE;
              end
            end
          end
          FBSE_B_ERASE: begin
            erase_all_req_o <= 1'b1;
            if (erase_all_req_o && erase_all_done_i) begin
              erase_all_req_o <= 1'b0;
              erased_reg <= 1'b1;
              state_reg <= FBSE_B_BRANCH;
            end
          end
          FBSE_B_BRANCH: begin
            rx_en_reg <= 1'b0;
            tx_en_reg <= 1'b0;
            boot_branch_o <= erased_reg;
            state_reg <= FBSE_B_DONE;
          end
          FBSE_B_DONE: state_reg <= FBSE_B_DONE;
          default: state_reg <= FBSE_B_IDLE;
        endcase
      end
    end
  end

  assign serial_rx_enable_o = rx_en_reg;
  assign serial_tx_enable_o = tx_en_reg;
  assign bit_rate_reg_o = bit_cycles_reg;
  assign boot_active_o = mode_valid_o && mode_o == FBSE_MODE_BOOT && state_reg != FBSE_B_DONE;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  ebr_swe_clear_a: assert property (!swe_reg |=> ebr_reg == 5'h00)
    else $error("block select not cleared without write enable");
  ebr_multi_clr_a: assert property (wr_ebr && swe_reg && !$onehot0(reg_wdata_i[4:0])
    |=> ebr_reg == 5'h00)
    else $error("multi-bit select not cleared");
  ebr_large_a: assert property (ebr_reg == 5'h10 |=> erase_first_o == 16'h1000
    && erase_last_o == 16'h7fff)
    else $error("large region bounds wrong");
  ebr_read_a: assert property (reg_rd_i && reg_addr_i == OFS_ERASE_BLOCK_SELECT
    |=> reg_rdata_o[7:5] == 3'h0)
    else $error("reserved select bits not zero");
  pd_enter_a: assert property (!srst_i && subactive_i && !power_down_disable_reg
    |=> flash_power_down_o)
    else $error("flash did not enter power-down");
  pd_disable_a: assert property (power_down_disable_reg |=> !flash_power_down_o)
    else $error("power-down despite disable");
  gate_wr_ignore_a: assert property (reg_wr_i && !gate_reg
    && reg_addr_i == OFS_FLASH_POWER_CONTROL |=> $stable(power_down_disable_reg))
    else $error("gated write took effect");
  gate_rd_zero_a: assert property (reg_rd_i && !gate_reg
    && reg_addr_i != OFS_FLASH_REGISTER_GATE |=> reg_rdata_o == 8'h00)
    else $error("gated read not zero");
  swe_refuse_a: assert property (!swe_reg |=> ctl_low_reg == 6'h00)
    else $error("control bits set without write enable");
  boot_branch_a: assert property (boot_branch_o |-> erased_reg && !rx_en_reg && !tx_en_reg
    && txd_o)
    else $error("branch before erase or with serial on");
  ram_range_a: assert property (ram_we_o |-> ram_addr_o >= RAM_LOAD_FIRST
    && ram_addr_o <= RAM_LOAD_LAST)
    else $error("load outside program area");
  ready_delay_a: assert property (state_reg == FBSE_B_IDLE ##1 state_reg == FBSE_B_WAIT
    |-> state_reg == FBSE_B_WAIT [*8])
    else $error("measurement armed too early");
  wdt_end_a: assert property (watchdog_ovf_i && boot_active_o |=> !boot_active_o)
    else $error("watchdog did not end boot mode");

  boot_done_c: cover property (boot_branch_o);
  ebr_clear_c: cover property (wr_ebr && swe_reg && !$onehot0(reg_wdata_i[4:0]));
  pd_c: cover property ($rose(flash_power_down_o));
  ack_c: cover property (state_reg == FBSE_B_ACK ##1 state_reg == FBSE_B_LEN_HI);
endmodule : fbse_top
`default_nettype wire

// ---- fbse_pkg.sv ----
/*
  Shared constants for the flash block select, power, gate and boot entry logic.
  Assumes one 50 MHz clock; a state is one clock cycle.
*/
package fbse_pkg;
  // Register port
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_FLASH_CONTROL_ONE = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_FLASH_STATUS_TWO = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_ERASE_BLOCK_SELECT = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_FLASH_POWER_CONTROL = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_FLASH_REGISTER_GATE = 3'h4;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // Field positions
  localparam int SW_WRITE_ENABLE_BIT = 6;
  localparam int FLASH_ERROR_BIT = 7;
  localparam int POWER_DOWN_DISABLE_BIT = 7;
  localparam int CTRL_REG_ACCESS_EN_BIT = 7;
  localparam int EBR_W = 5;

  // Erase regions, index is the select bit
  localparam logic [EBR_W-1:0][15:0] REGION_FIRST = {16'h1000, 16'h0c00, 16'h0800,
                                                     16'h0400, 16'h0000};
  localparam logic [EBR_W-1:0][15:0] REGION_LAST = {16'h7fff, 16'h0fff, 16'h0bff,
                                                    16'h07ff, 16'h03ff};

  // Boot timing and framing
  localparam int CLK_HZ = 50_000_000;
  localparam int READY_STATES = 100;
  localparam int FRAME_DATA_BITS = 8;
  localparam int FRAME_STOP_BITS = 1;
  localparam int FRAME_BITS = 1 + FRAME_DATA_BITS + FRAME_STOP_BITS;
  localparam int ZERO_BYTE_LOW_BITS = 1 + FRAME_DATA_BITS;
  localparam logic [7:0] ADJUST_DONE_BYTE = 8'h00;
  localparam logic [7:0] HOST_ACK_BYTE = 8'h55;
  localparam logic [15:0] RAM_LOAD_FIRST = 16'hf780;
  localparam logic [15:0] RAM_LOAD_LAST = 16'hfeef;

  typedef enum logic [1:0] {FBSE_MODE_USER, FBSE_MODE_BOOT, FBSE_MODE_PROG} fbse_mode_t;

  typedef enum logic [3:0] {
    FBSE_B_IDLE, FBSE_B_WAIT, FBSE_B_FALL, FBSE_B_LOW, FBSE_B_DIV, FBSE_B_ADJ,
    FBSE_B_ACK, FBSE_B_LEN_HI, FBSE_B_LEN_LO, FBSE_B_LOAD, FBSE_B_ERASE,
    FBSE_B_BRANCH, FBSE_B_DONE
  } fbse_boot_t;
endpackage : fbse_pkg

// ---- fbse_sync3.sv ----
/*
  Three-stage pin synchroniser; output follows once stages two and three agree.
  Assumes inputs are asynchronous to clk_i; stages carry no reset so pin levels
  pass through while reset is held.
*/
`timescale 1ns/1ps
`default_nettype none
module fbse_sync3 #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk_i,
  // Data
  input wire logic [W-1:0] d_i,
  output var logic [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_i) begin
    s1_reg <= d_i;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // Per bit, take the level once two stages agree
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        q_o[i] <= s3_reg[i];
      end
    end
  end
endmodule : fbse_sync3
`default_nettype wire

// ---- fbse_host_model.sv ----
/*
  Host computer model for the boot serial link, 8 data bits, 1 stop, no parity.
  Assumes a pulled-up line and a fixed bit time of BIT clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module fbse_host_model #(
  parameter int BIT = 20
) (
  // Clock and start
  input wire logic clk_i,
  input wire logic go_i,
  // Serial pins
  input wire logic txd_i,
  output var logic rxd_o,
  // Status
  output var logic adj_seen_o,
  output var logic stop_err_o
);
  logic [7:0] payload[5] = '{8'h55, 8'h00, 8'h02, 8'ha5, 8'h3c};

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT) @(posedge clk_i);
    end
  endtask : send_byte

  initial begin : host_tx
    rxd_o = 1'b1;
    wait (go_i === 1'b1);
    @(posedge clk_i);
    while (adj_seen_o !== 1'b1) send_byte(8'h00);
    repeat (2 * BIT) @(posedge clk_i);
    foreach (payload[i]) send_byte(payload[i]);
  end

  initial begin : host_rx
    logic [7:0] b;
    adj_seen_o = 1'b0;
    stop_err_o = 1'b0;
    forever begin
      @(negedge txd_i);
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk_i);
        b[i] = txd_i;
      end
      repeat (BIT) @(posedge clk_i);
      if (txd_i !== 1'b1) stop_err_o = 1'b1;
      if (b === 8'h00) adj_seen_o = 1'b1;
    end
  end
endmodule : fbse_host_model
`default_nettype wire

// ---- tb_top.sv ----
/*
  Testbench for fbse_top: register port, mode pins, boot link.
  Assumes fbse_host_model on the serial pins; the bench acts as eraser.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fbse_pkg::*;
  localparam int BIT = 20;
  logic clk_i = 1'b0, srst_i, reg_wr_i, reg_rd_i, test_i, nmi_n_i, port8_bit5_i;
  logic portb_bit0_i, portb_bit1_i, portb_bit2_i, subactive_i, flash_error_i;
  logic watchdog_ovf_i, rxd_i, erase_all_done_i, host_go, adj_seen, stop_err;
  logic mode_valid_o, flash_power_down_o, erase_region_valid_o, txd_o, done_given;
  logic serial_rx_enable_o, serial_tx_enable_o, ram_we_o, erase_all_req_o;
  logic boot_branch_o, boot_active_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, ram_wdata_o;
  logic [15:0] erase_first_o, erase_last_o, ram_addr_o;
  logic [19:0] bit_rate_reg_o;
  fbse_mode_t mode_o;
  logic [15:0] ram_a[$];
  logic [7:0] ram_d[$];
  int error_cnt = 0, samples_checked = 0, branch_cnt = 0, early_cnt = 0;
  logic [15:0] first_t[5] = '{16'h0000, 16'h0400, 16'h0800, 16'h0c00, 16'h1000};
  logic [15:0] last_t[5] = '{16'h03ff, 16'h07ff, 16'h0bff, 16'h0fff, 16'h7fff};
  logic [3:0] pins_t[4] = '{4'b0010, 4'b1100, 4'b0000, 4'b0100};
  fbse_mode_t mode_t[4] = '{FBSE_MODE_BOOT, FBSE_MODE_PROG, FBSE_MODE_USER, FBSE_MODE_USER};

  always #10 clk_i = ~clk_i;

  fbse_top #(.CNT_W(20)) u_dut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .test_i(test_i), .nmi_n_i(nmi_n_i),
    .port8_bit5_i(port8_bit5_i), .portb_bit0_i(portb_bit0_i), .portb_bit1_i(portb_bit1_i),
    .portb_bit2_i(portb_bit2_i), .mode_o(mode_o), .mode_valid_o(mode_valid_o),
    .subactive_i(subactive_i), .flash_error_i(flash_error_i),
    .watchdog_ovf_i(watchdog_ovf_i), .flash_power_down_o(flash_power_down_o),
    .erase_region_valid_o(erase_region_valid_o), .erase_first_o(erase_first_o),
    .erase_last_o(erase_last_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .serial_rx_enable_o(serial_rx_enable_o), .serial_tx_enable_o(serial_tx_enable_o),
    .bit_rate_reg_o(bit_rate_reg_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
    .ram_wdata_o(ram_wdata_o), .erase_all_req_o(erase_all_req_o),
    .erase_all_done_i(erase_all_done_i), .boot_branch_o(boot_branch_o),
    .boot_active_o(boot_active_o));

  fbse_host_model #(.BIT(BIT)) u_host (.clk_i(clk_i), .go_i(host_go), .txd_i(txd_o),
    .rxd_o(rxd_i), .adj_seen_o(adj_seen), .stop_err_o(stop_err));

  always @(posedge clk_i) begin
    if (ram_we_o === 1'b1) ram_a.push_back(ram_addr_o);
    if (ram_we_o === 1'b1) ram_d.push_back(ram_wdata_o);
    if (boot_branch_o === 1'b1) branch_cnt++;
    if (boot_branch_o === 1'b1 && !done_given) early_cnt++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] dat);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= dat;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rc(input string n, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check(n, reg_rdata_o, e);
  endtask : rc

  task automatic do_reset(input logic [3:0] p);
    @(posedge clk_i);
    srst_i <= 1'b1;
    {test_i, nmi_n_i, port8_bit5_i, portb_bit0_i} <= p;
    portb_bit1_i <= p[0];
    portb_bit2_i <= p[0];
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : do_reset

  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  initial begin : watchdog
    repeat (50000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end

  initial begin : main
    {srst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {test_i, nmi_n_i, port8_bit5_i, portb_bit0_i, portb_bit1_i, portb_bit2_i} = '0;
    {subactive_i, watchdog_ovf_i, erase_all_done_i, host_go, done_given} = '0;
    flash_error_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      do_reset(pins_t[i]);
      check("mode", mode_o, mode_t[i]);
      check("mode valid", mode_valid_o, 1'b1);
    end
    rc("gate reset", OFS_FLASH_REGISTER_GATE, 8'h00);
    wr(OFS_FLASH_CONTROL_ONE, 8'h40);
    wr(OFS_FLASH_REGISTER_GATE, 8'hff);
    rc("gate", OFS_FLASH_REGISTER_GATE, 8'h80);
    rc("ctl refused", OFS_FLASH_CONTROL_ONE, 8'h00);
    wr(OFS_FLASH_CONTROL_ONE, 8'h3f);
    rc("ctl locked", OFS_FLASH_CONTROL_ONE, 8'h00);
    wr(OFS_ERASE_BLOCK_SELECT, 8'h01);
    rc("ebr locked", OFS_ERASE_BLOCK_SELECT, 8'h00);
    rc("status", OFS_FLASH_STATUS_TWO, 8'h80);
    wr(OFS_FLASH_CONTROL_ONE, 8'h40);
    rc("ctl", OFS_FLASH_CONTROL_ONE, 8'h40);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_ERASE_BLOCK_SELECT, 8'he0 | (8'h01 << i));
      rc("ebr", OFS_ERASE_BLOCK_SELECT, 8'h01 << i);
      check("first", erase_first_o, first_t[i]);
      check("last", erase_last_o, last_t[i]);
      check("region valid", erase_region_valid_o, 1'b1);
    end
    wr(OFS_ERASE_BLOCK_SELECT, 8'h03);
    rc("ebr multi", OFS_ERASE_BLOCK_SELECT, 8'h00);
    wr(OFS_ERASE_BLOCK_SELECT, 8'h10);
    wr(OFS_FLASH_CONTROL_ONE, 8'h00);
    rc("ebr cleared", OFS_ERASE_BLOCK_SELECT, 8'h00);
    @(posedge clk_i);
    subactive_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 check("power down", flash_power_down_o, 1'b1);
    wr(OFS_FLASH_POWER_CONTROL, 8'h80);
    repeat (2) @(posedge clk_i);
    #1 check("power normal", flash_power_down_o, 1'b0);
    wr(OFS_FLASH_REGISTER_GATE, 8'h00);
    rc("pwc refused", OFS_FLASH_POWER_CONTROL, 8'h00);
    wr(OFS_FLASH_POWER_CONTROL, 8'h00);
    wr(OFS_FLASH_REGISTER_GATE, 8'h80);
    rc("pwc kept", OFS_FLASH_POWER_CONTROL, 8'h80);
    rc("unmapped", 3'h5, 8'h00);
    do_reset(4'b0010);
    host_go <= 1'b1;
    check("boot active", boot_active_o, 1'b1);
    for (int k = 0; k < 20000 && erase_all_req_o !== 1'b1; k++) @(posedge clk_i);
    check("erase req", erase_all_req_o, 1'b1);
    check("ram count", ram_a.size(), 2);
    for (int i = 0; i < 2; i++) begin
      check("ram addr", ram_a[i], 16'hf780 + i);
      check("ram data", ram_d[i], i ? 8'h3c : 8'ha5);
    end
    repeat (30) @(posedge clk_i);
    erase_all_done_i <= 1'b1;
    done_given <= 1'b1;
    @(posedge clk_i);
    erase_all_done_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    #1 check("branch", branch_cnt, 1);
    check("early branch", early_cnt, 0);
    check("adjust byte", adj_seen, 1'b1);
    check("stop bit", stop_err, 1'b0);
    check("bit rate", bit_rate_reg_o >= BIT - 1 && bit_rate_reg_o <= BIT, 1'b1);
    check("enables", {serial_rx_enable_o, serial_tx_enable_o, txd_o}, 3'b001);
    do_reset(4'b0010);
    check("boot again", boot_active_o, 1'b1);
    @(posedge clk_i);
    watchdog_ovf_i <= 1'b1;
    @(posedge clk_i);
    watchdog_ovf_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 check("wdt ends boot", boot_active_o, 1'b0);
    check("wdt no branch", branch_cnt, 1);
    do_reset(4'b0100);
    check("reset ends boot", {boot_active_o, mode_o}, {1'b0, FBSE_MODE_USER});
    final_report();
  end
endmodule : tb_top
`default_nettype wire
